// ===== hdl/ext_bus_master.sv
module ext_bus_master
  import xbus_pkg::*;
(
  input wire logic mclk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [1:0] mode_i, // Chip mode
  input wire logic width_en_i, // Config: width code pins enabled
  input wire logic width_en_set_i, // Config: override width default
  input wire logic core_en_i, // Config: core-state pins enabled
  input wire logic core_en_set_i, // Config: override core default
  input wire logic [3:0] core_state_i, // Processor status to show
  input wire logic req_valid_i, // Internal request valid
  output logic req_ready_o, // Internal request taken
  input wire req_t req_i, // Internal request
  output logic rsp_valid_o, // Answer valid
  input wire logic rsp_ready_i, // Answer taken
  output rsp_t rsp_o, // Answer data
  input wire logic cs_active_i, // A chip select matches
  input wire logic cs_port16_i, // Matched port is 16 bits
  input wire logic cs_we_i, // Matched channel write-enable option
  input wire logic cs_ack_i, // Internal chip-select acknowledge
  input wire logic cycle_acknowledge_n_i, // External acknowledge
  input wire logic cycle_error_acknowledge_n_i, // External error
  output pins_t pins_o, // Address and control pins
  output logic width_pins_oe_n_o, // Low: width code pins driven
  output logic [1:0] edge_irq_input_o, // Width pins as edge inputs
  input wire logic [1:0] width_pins_i, // Width pin levels
  output logic [3:0] core_state_pins_o, // Core-state pin values
  output logic core_pins_oe_n_o, // Low: core-state pins driven
  output logic [3:0] core_irq_o, // Core-state pins as edge inputs
  input wire logic [3:0] core_pins_i, // Core-state pin levels
  input wire logic [DATA_W-1:0] data_i, // External data bus in
  output logic [DATA_W-1:0] data_o, // External data bus out
  output logic data_oe_n_o // Low: data bus driven
);

  // ----------------------------------------------------------------
  // Lane constants
  // ----------------------------------------------------------------
  // Read lanes kept per operand, the rest forced to zero
  localparam logic [DATA_W-1:0] BYTE_LANE0 = 32'hff000000;
  localparam logic [DATA_W-1:0] HALF_HIGH = 32'hffff0000;
  localparam logic [DATA_W-1:0] HALF_LOW = 32'h0000ffff;
  localparam logic [3:0] PAIR_HI_ON = 4'h3;
  localparam logic [3:0] PAIR_LO_ON = 4'hc;

  // ----------------------------------------------------------------
  // Pin function selection
  // ----------------------------------------------------------------
  logic width_on;
  logic core_on;
  assign width_on = width_en_set_i ? width_en_i : (mode_i != MODE_SINGLE);
  assign core_on = core_en_set_i ? core_en_i : (mode_i == MODE_EMUL);
  assign width_pins_oe_n_o = ~width_on;
  assign edge_irq_input_o = width_on ? 2'h0 : width_pins_i;
  assign core_pins_oe_n_o = ~core_on;
  assign core_irq_o = core_on ? 4'h0 : core_pins_i;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      core_state_pins_o <= 4'h0;
    end else begin
      core_state_pins_o <= core_state_i;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] width_code(input op_size_t s);
    case (s)
      SZ_BYTE: width_code = TW_BYTE;
      SZ_HALF: width_code = TW_HALF;
      default: width_code = TW_WORD;
    endcase
  endfunction

  // Active-low strobes per size, offset and port width
  function automatic logic [3:0] lanes_n(input op_size_t s, input logic [1:0] off,
                                         input logic p16);
    logic [3:0] on;
    on = 4'h0;
    case (s)
      SZ_BYTE: begin
        if (p16) begin
          on = off[0] ? 4'h2 : 4'h1;
        end else begin
          on = 4'h1 << off;
        end
      end
      SZ_HALF: begin
        on = (p16 || !off[1]) ? PAIR_HI_ON : PAIR_LO_ON;
      end
      default: begin
        on = p16 ? PAIR_HI_ON : 4'hf;
      end
    endcase
    lanes_n = ~on;
  endfunction

  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRST,
    ST_WAIT,
    ST_SECOND
  } bus_state_t;

  bus_state_t state_r;
  req_t cur_r;
  logic port16_r;
  logic split_r;
  logic half2_r;
  logic we_mode_r;
  logic [15:0] hi_half_r;
  logic misaligned;
  logic active;
  logic err_r;
  logic ack;
  logic err;
  logic buf_ready;
  logic buf_push;
  rsp_t buf_in;

  always_comb begin
    case (req_i.size)
      SZ_HALF: misaligned = req_i.addr[0];
      SZ_WORD: misaligned = |req_i.addr[1:0];
      default: misaligned = 1'b0;
    endcase
  end

  assign active = (state_r != ST_IDLE);
  assign req_ready_o = !active && buf_ready;
  assign ack = ~cycle_acknowledge_n_i | cs_ack_i;
  assign err = ~cycle_error_acknowledge_n_i;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (req_valid_i && req_ready_o && !misaligned) begin
            state_r <= ST_FIRST;
          end
        end
        ST_FIRST, ST_WAIT: begin
          if (err || ack) begin
            state_r <= ST_SECOND;
          end else begin
            state_r <= ST_WAIT;
          end
        end
        ST_SECOND: begin
          // An error in the first half ends a split word
          if (split_r && !half2_r && !err_r) begin
            state_r <= ST_FIRST;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Cycle error remembered into the second state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      err_r <= 1'b0;
    end else if (state_r == ST_FIRST || state_r == ST_WAIT) begin
      err_r <= err;
    end
  end

  // Captured request and port attributes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cur_r <= '0;
      port16_r <= 1'b0;
      split_r <= 1'b0;
      we_mode_r <= 1'b0;
    end else if (state_r == ST_IDLE && req_valid_i && req_ready_o) begin
      cur_r <= req_i;
      port16_r <= cs_active_i && cs_port16_i;
      split_r <= cs_active_i && cs_port16_i && (req_i.size == SZ_WORD);
      we_mode_r <= cs_active_i && cs_we_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      half2_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      half2_r <= 1'b0;
    end else if (state_r == ST_SECOND && split_r) begin
      half2_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // External pins, registered and stable through the cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pins_o <= '{addr: '0, rd_wr: 1'b1, width_code: TW_WORD, acc_type: 3'h0,
                  oe_n: 1'b1, strobe_n: STROBE_OFF};
    end else if (state_r == ST_SECOND && (!split_r || half2_r || err_r)) begin
      pins_o.oe_n <= 1'b1;
      pins_o.strobe_n <= STROBE_OFF;
    end else if (state_r == ST_IDLE && req_valid_i && req_ready_o && !misaligned) begin
      pins_o.addr <= (req_i.size == SZ_WORD) ? (req_i.addr & LOW2_MASK) : req_i.addr;
      pins_o.rd_wr <= req_i.rd;
      pins_o.width_code <= width_code(req_i.size);
      pins_o.acc_type <= req_i.acc_type;
      pins_o.oe_n <= ~req_i.rd;
      pins_o.strobe_n <= (req_i.rd && cs_active_i && cs_we_i) ? STROBE_OFF :
                         lanes_n(req_i.size, req_i.addr[1:0], cs_active_i && cs_port16_i);
    end else if (state_r == ST_SECOND && split_r && !half2_r) begin
      pins_o.addr <= cur_r.addr | A1_BIT;
      pins_o.width_code <= TW_HALF;
      pins_o.strobe_n <= (cur_r.rd && we_mode_r) ? STROBE_OFF : ~PAIR_HI_ON;
    end
  end // no change during second state except at its end

  // ----------------------------------------------------------------
  // Write data drive
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      data_o <= '0;
      data_oe_n_o <= 1'b1;
    end else if (state_r == ST_IDLE && req_valid_i && req_ready_o && !misaligned) begin
      data_o <= req_i.wdata;
      data_oe_n_o <= req_i.rd;
    end else if (state_r == ST_SECOND && (!split_r || half2_r || err_r)) begin
      data_oe_n_o <= 1'b1;
    end else if (state_r == ST_SECOND && split_r && !half2_r) begin
      data_o <= {cur_r.wdata[15:0], cur_r.wdata[15:0]};
    end
  end

  // ----------------------------------------------------------------
  // Read data capture and steering
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] rd_lanes;
  always_comb begin
    // 16-bit port: the addressed half arrives on the upper lines
    rd_lanes = data_i;
    if (port16_r) begin
      rd_lanes = cur_r.addr[1] ? {16'h0000, data_i[31:16]} :
                                 {data_i[31:16], 16'h0000};
    end
    case (cur_r.size)
      SZ_BYTE: rd_word = rd_lanes & (BYTE_LANE0 >> {cur_r.addr[1:0], 3'h0});
      SZ_HALF: rd_word = rd_lanes & (cur_r.addr[1] ? HALF_LOW : HALF_HIGH);
      default: rd_word = port16_r ? {hi_half_r, data_i[31:16]} : data_i;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hi_half_r <= 16'h0000;
    end else if (state_r == ST_SECOND && split_r && !half2_r) begin
      hi_half_r <= data_i[31:16];
    end
  end

  // Split word answers after its second half, or after an error in its first half
  assign buf_push = (state_r == ST_SECOND) && (!split_r || half2_r || err_r);
  assign buf_in = '{rdata: cur_r.rd ? rd_word : '0, err: err_r};

  // ----------------------------------------------------------------
  // Two-entry answer buffer
  // ----------------------------------------------------------------
  rsp_t slot_r [2];
  logic [1:0] count_r;
  logic rd_ptr_r;
  logic wr_ptr_r;
  logic buf_pop;

  assign buf_ready = (count_r < 2'h2);
  assign rsp_valid_o = (count_r != 2'h0);
  assign rsp_o = slot_r[rd_ptr_r];
  assign buf_pop = rsp_valid_o && rsp_ready_i;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count_r <= 2'h0;
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
    end else begin
      if (buf_push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (buf_pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else if (buf_push) begin
      slot_r[wr_ptr_r] <= buf_in;
    end
  end

endmodule

// ===== shared/xbus_pkg.sv
package xbus_pkg;

  // Transfer-width codes, upper bit first
  localparam logic [1:0] TW_BYTE = 2'h1;
  localparam logic [1:0] TW_HALF = 2'h2;
  localparam logic [1:0] TW_WORD = 2'h0;

  // Operation modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_MASTER = 2'h1;
  localparam logic [1:0] MODE_EMUL = 2'h2;

  localparam int ADDR_W = 23;
  localparam int DATA_W = 32;
  localparam logic [3:0] STROBE_OFF = 4'hf;
  localparam logic [ADDR_W-1:0] A1_BIT = 23'h000002;
  localparam logic [ADDR_W-1:0] LOW2_MASK = 23'h7ffffc;

  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_HALF,
    SZ_WORD
  } op_size_t;

  // Internal-bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    op_size_t size;
    logic rd;
    logic [2:0] acc_type;
    logic [DATA_W-1:0] wdata;
  } req_t;

  // Internal-bus answer
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic err;
  } rsp_t;

  // External pin group
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rd_wr;
    logic [1:0] width_code;
    logic [2:0] acc_type;
    logic oe_n;
    logic [3:0] strobe_n;
  } pins_t;

endpackage

// ===== tb/ext_bus_master_properties.sv
module ext_bus_master_checker
  import xbus_pkg::*;
(
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [1:0] mode_i, // Mode
  input wire logic width_en_set_i, // Width override
  input wire logic core_en_set_i, // Core override
  input wire logic req_valid_i, // Request valid
  input wire logic req_ready_o, // Request ready
  input wire req_t req_i, // Request
  input wire logic cs_active_i, // Select match
  input wire logic cs_port16_i, // 16-bit port
  input wire logic cs_we_i, // Write-enable option
  input wire pins_t pins_o, // Bus pins
  input wire logic width_pins_oe_n_o, // Width pin enable
  input wire logic [1:0] edge_irq_input_o, // Width pins as irq
  input wire logic [1:0] width_pins_i, // Width pin levels
  input wire logic core_pins_oe_n_o // Core pin enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  logic p16;
  assign take = req_valid_i && req_ready_o && req_i.rd && (req_i.size == SZ_BYTE ||
    (req_i.size == SZ_HALF && !req_i.addr[0]) || req_i.addr[1:0] == 2'h0);
  assign p16 = cs_active_i && cs_port16_i;
  byte_code_a: assert property (take && req_i.size == SZ_BYTE |=>
    pins_o.width_code == TW_BYTE) else $error("byte width code wrong");
  half_code_a: assert property (take && req_i.size == SZ_HALF |=>
    pins_o.width_code == TW_HALF) else $error("half width code wrong");
  first_state_a: assert property (take |=> pins_o.addr == $past(req_i.addr) &&
    pins_o.rd_wr && pins_o.acc_type == $past(req_i.acc_type)) else $error("first state pins");
  read_oe_a: assert property (take |=> !pins_o.oe_n)
    else $error("output enable not asserted");
  word_addr_a: assert property (!pins_o.oe_n && pins_o.width_code == TW_WORD |->
    pins_o.addr[1:0] == 2'h0) else $error("word address low bits");
  split_word_a: assert property (take && req_i.size == SZ_WORD && p16 |=>
    pins_o.width_code == TW_WORD ##[1:40] (!pins_o.oe_n && pins_o.width_code == TW_HALF
    && pins_o.addr[1:0] == 2'h2)) else $error("split word second cycle");
  lane_strobe_a: assert property (take && req_i.size == SZ_BYTE && !p16 && !cs_we_i |=>
    pins_o.strobe_n == ~(4'h1 << $past(req_i.addr[1:0]))) else $error("byte strobe lane");
  we_strobe_a: assert property (take && cs_active_i && cs_we_i |=>
    pins_o.strobe_n == STROBE_OFF) else $error("strobes on read with write enables");
  hold_second_a: assert property ($rose(pins_o.oe_n) |->
    $past(pins_o) == $past(pins_o, 2)) else $error("pins moved in second state");
  width_off_a: assert property (mode_i == MODE_SINGLE && !width_en_set_i |->
    width_pins_oe_n_o && edge_irq_input_o == width_pins_i) else $error("width pins default");
  core_off_a: assert property (mode_i != MODE_EMUL && !core_en_set_i |->
    core_pins_oe_n_o) else $error("core pins default");
endmodule

bind ext_bus_master ext_bus_master_checker chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode_i),
  .width_en_set_i(width_en_set_i), .core_en_set_i(core_en_set_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .req_i(req_i), .cs_active_i(cs_active_i),
  .cs_port16_i(cs_port16_i), .cs_we_i(cs_we_i), .pins_o(pins_o),
  .width_pins_oe_n_o(width_pins_oe_n_o), .edge_irq_input_o(edge_irq_input_o),
  .width_pins_i(width_pins_i), .core_pins_oe_n_o(core_pins_oe_n_o));

// ===== tb/mem_partner.sv
module mem_partner
  import xbus_pkg::*;
(
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Reset
  input wire pins_t pins_i, // Master pins
  input wire logic [3:0] waits_i, // Wait states to add
  input wire logic fail_i, // Answer with error
  output logic [DATA_W-1:0] data_o, // Read data
  output logic ack_n_o, // Acknowledge
  output logic err_n_o // Error acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic idle_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] last_r;
  logic drive;
  logic fresh;
  logic hit;
  assign drive = !pins_i.oe_n && pins_i.rd_wr;
  assign fresh = drive && (idle_r || pins_i.addr != addr_r);
  assign hit = drive && (fresh ? 4'h0 : cnt_r) == waits_i;
  assign ack_n_o = !(hit && !fail_i);
  assign err_n_o = !(hit && fail_i);
  // Released bus toggles so stale data is never read
  assign data_o = drive ? {pins_i.addr[15:0], ~pins_i.addr[15:0]} : ~last_r;
  always_ff @(posedge mclk_i) begin
    idle_r <= rst_i || !drive;
    addr_r <= pins_i.addr;
    cnt_r <= fresh ? 4'h1 : cnt_r + 4'h1;
    last_r <= data_o;
  end
endmodule

// ===== tb/test_ext_bus_master.sv
module test_ext_bus_master
  import xbus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rst_i, width_en_i, width_en_set_i, core_en_i, core_en_set_i;
  logic [1:0] mode_i, edge_irq_input_o, width_pins_i;
  logic [3:0] core_state_i, core_state_pins_o, core_irq_o, core_pins_i, waits;
  logic req_valid_i, req_ready_o, rsp_valid_o, rsp_ready_i, fail, data_oe_n_o;
  logic cs_active_i, cs_port16_i, cs_we_i, cs_ack_i, width_pins_oe_n_o, core_pins_oe_n_o;
  logic cycle_acknowledge_n_i, cycle_error_acknowledge_n_i;
  logic [DATA_W-1:0] data_i, data_o;
  req_t req_i;
  rsp_t rsp_o;
  pins_t pins_o;
  int errors = 0;
  int n_compared = 0;
  ext_bus_master uut (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode_i), .width_en_i(width_en_i),
    .width_en_set_i(width_en_set_i), .core_en_i(core_en_i), .core_en_set_i(core_en_set_i),
    .core_state_i(core_state_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .rsp_o(rsp_o),
    .cs_active_i(cs_active_i), .cs_port16_i(cs_port16_i), .cs_we_i(cs_we_i),
    .cs_ack_i(cs_ack_i), .cycle_acknowledge_n_i(cycle_acknowledge_n_i),
    .cycle_error_acknowledge_n_i(cycle_error_acknowledge_n_i), .pins_o(pins_o),
    .width_pins_oe_n_o(width_pins_oe_n_o), .edge_irq_input_o(edge_irq_input_o),
    .width_pins_i(width_pins_i), .core_state_pins_o(core_state_pins_o),
    .core_pins_oe_n_o(core_pins_oe_n_o), .core_irq_o(core_irq_o), .core_pins_i(core_pins_i),
    .data_i(data_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o));
  mem_partner far_end (.mclk_i(mclk_i), .rst_i(rst_i), .pins_i(pins_o), .waits_i(waits),
    .fail_i(fail), .data_o(data_i), .ack_n_o(cycle_acknowledge_n_i),
    .err_n_o(cycle_error_acknowledge_n_i));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // ----
  // Helpers
  // ----
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic hang();
    errors++;
    $display("Error %0t: wait ran out", $time);
    test_done();
  endtask
  function automatic logic [31:0] expv(input logic [22:0] a, input op_size_t sz, input logic p16);
    logic [31:0] v;
    logic [31:0] m;
    logic [1:0] s;
    v = {a[15:0], ~a[15:0]};
    if (sz == SZ_WORD && p16) return {a[15:0], a[15:0] | 16'h2};
    m = sz == SZ_BYTE ? 32'hff000000 : sz == SZ_HALF ? 32'hffff0000 : 32'hffffffff;
    s = p16 ? {1'b0, a[0]} : a[1:0];
    return ((v << (8 * s)) & m) >> (8 * a[1:0]);
  endfunction
  task automatic send(input logic [22:0] a, input op_size_t sz, input logic p16, input logic we);
    int i;
    @(negedge mclk_i);
    req_i = '{a, sz, 1'b1, 3'h5, 32'h0};
    cs_active_i = p16 | we;
    cs_port16_i = p16;
    cs_we_i = we;
    req_valid_i = 1'b1;
    for (i = 0; i < 40 && req_ready_o !== 1'b1; i++) @(negedge mclk_i);
    if (i == 40) hang();
    @(negedge mclk_i);
    req_valid_i = 1'b0;
  endtask
  task automatic get(input logic [31:0] exp, input logic err, output int k);
    for (k = 0; k < 60 && rsp_valid_o !== 1'b1; k++) @(negedge mclk_i);
    if (k == 60) hang();
    if (!err) chk32(rsp_o.rdata, exp);
    chk1(rsp_o.err, err);
    chk1(data_oe_n_o, 1'b1);
    rsp_ready_i = 1'b1;
    @(negedge mclk_i);
    rsp_ready_i = 1'b0;
  endtask
  task automatic rd(input logic [22:0] a, input op_size_t sz, input logic p16, input logic we,
      input logic [3:0] w, input logic f);
    int k;
    waits = w;
    fail = f;
    send(a, sz, p16, we);
    get(expv(a, sz, p16), f, k);
    chk32(32'(k), 32'((sz == SZ_WORD && p16) ? 4 + 2 * w : 2 + w));
  endtask
  // ----
  // Scenarios
  // ----
  task automatic test_pins();
    for (int m = 0; m < 3; m++) begin
      mode_i = 2'(m);
      @(negedge mclk_i);
      chk1(width_pins_oe_n_o, m == 0);
      chk1(core_pins_oe_n_o, m != 2);
      chk32(32'(edge_irq_input_o), 32'(m == 0 ? width_pins_i : 2'h0));
      chk32(32'(core_irq_o), 32'(m != 2 ? core_pins_i : 4'h0));
    end
    chk32(32'(core_state_pins_o), 32'(core_state_i));
    {width_en_set_i, core_en_set_i} = 2'h3;
    @(negedge mclk_i);
    chk1(width_pins_oe_n_o, 1'b1);
    chk32(32'(edge_irq_input_o), 32'(width_pins_i));
    chk32(32'(core_irq_o), 32'(core_pins_i));
    {width_en_set_i, core_en_set_i, mode_i} = {2'h0, MODE_MASTER};
    $display("Pin functions done");
  endtask
  task automatic test_sizes();
    for (int p = 0; p < 2; p++) begin
      for (int o = 0; o < 4; o++) begin
        rd(23'h01a4c0 + 23'(o), SZ_BYTE, p[0], 1'b0, 4'h0, 1'b0);
        if (o[0] == 1'b0) rd(23'h02b5d0 + 23'(o), SZ_HALF, p[0], 1'b0, 4'h0, 1'b0);
      end
      rd(23'h03c6e4, SZ_WORD, p[0], 1'b0, 4'h0, 1'b0);
    end
    $display("Sizes and lanes done");
  endtask
  task automatic test_waits_errors();
    int k;
    rd(23'h0004f8, SZ_WORD, 1'b0, 1'b0, 4'h1, 1'b0);
    rd(23'h000532, SZ_HALF, 1'b1, 1'b0, 4'h5, 1'b0);
    rd(23'h000603, SZ_BYTE, 1'b0, 1'b0, 4'h2, 1'b1);
    rd(23'h000604, SZ_WORD, 1'b0, 1'b1, 4'h0, 1'b0);
    rd(23'h000628, SZ_WORD, 1'b1, 1'b0, 4'h2, 1'b0);
    waits = 4'h3;
    cs_ack_i = 1'b1;
    send(23'h000642, SZ_HALF, 1'b0, 1'b0);
    get(expv(23'h000642, SZ_HALF, 1'b0), 1'b0, k);
    chk32(32'(k), 32'h2);
    cs_ack_i = 1'b0;
    $display("Waits, errors and write enables done");
  endtask
  task automatic test_misaligned();
    send(23'h000101, SZ_HALF, 1'b0, 1'b0);
    send(23'h000102, SZ_WORD, 1'b0, 1'b0);
    repeat (8) begin
      @(negedge mclk_i);
      chk1(rsp_valid_o, 1'b0);
    end
    rd(23'h000108, SZ_WORD, 1'b0, 1'b0, 4'h0, 1'b0);
    $display("Misaligned done");
  endtask
  task automatic test_stall();
    int k;
    send(23'h000710, SZ_WORD, 1'b0, 1'b0);
    send(23'h000721, SZ_BYTE, 1'b0, 1'b0);
    repeat (8) @(negedge mclk_i);
    chk1(req_ready_o, 1'b0);
    get(expv(23'h000710, SZ_WORD, 1'b0), 1'b0, k);
    @(negedge mclk_i);
    get(expv(23'h000721, SZ_BYTE, 1'b0), 1'b0, k);
    $display("Stall done");
  endtask
  initial begin
    rst_i = 1'b1;
    {mode_i, width_en_i, width_en_set_i, core_en_i, core_en_set_i} = {MODE_MASTER, 4'h0};
    {core_state_i, core_pins_i, width_pins_i, waits, fail} = {4'h9, 4'h6, 2'h2, 4'h0, 1'b0};
    {req_valid_i, rsp_ready_i, cs_active_i, cs_port16_i, cs_we_i, cs_ack_i} = 6'h0;
    req_i = '0;
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    test_pins();
    test_sizes();
    test_waits_errors();
    test_misaligned();
    test_stall();
    test_done();
  end
endmodule
